// file: rsc_core_model.sv
// core-side partner: system clock source and watchdog tick counter
`timescale 1ns/1ps
module rsc_core_model (
	input wire logic i_clock, // bench clock
	input wire logic i_system_reset, // reset from the controller
	input wire logic i_stop, // hold the system clock at its level
	input wire logic i_watchdog_tick, // watchdog clock pulse
	output logic o_system_clock, // system clock level
	output int o_ticks // ticks seen since reset left
);
	// system clock toggles, stands still at its level when stopped
	initial o_system_clock = 1'b0;
	always @(posedge i_clock) begin
		if (!i_stop) begin
			o_system_clock <= ~o_system_clock;
		end
	end
	// tick count restarts with every system reset
	always_ff @(posedge i_clock) begin
		if (i_system_reset) begin
			o_ticks <= 0;
		end else if (i_watchdog_tick) begin
			o_ticks <= o_ticks + 1;
		end
	end
endmodule // rsc_core_model

// file: rsc_pkg.sv
// constants, field layout and states of the reset source controller
package rsc_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25; // 40 mhz system clock
	localparam int RESET_DELAY_NS = 5000; // 5.0 us least release delay
	localparam int RESET_DELAY_CYC =
		(RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CLOSS_MIN_US = 100; // clock-loss timeout, least
	localparam int CLOSS_TYP_US = 220; // clock-loss timeout, typical
	localparam int CLOSS_MAX_US = 500; // clock-loss timeout, most
	localparam int CLOSS_MIN_CYC = CLOSS_MIN_US * 1000 / CLK_PERIOD_NS;
	localparam int CLOSS_TYP_CYC = CLOSS_TYP_US * 1000 / CLK_PERIOD_NS;
	localparam int CLOSS_MAX_CYC = CLOSS_MAX_US * 1000 / CLK_PERIOD_NS;
	localparam int WDT_PRESCALE = 12; // watchdog clock divider

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int REG_W = 8; // register width
	localparam int ADDR_W = 16; // code address width
	localparam int CNT_W = 16; // clock-loss counter width
	localparam int DLY_W = 8; // release delay counter width
	localparam int PRE_W = 4; // watchdog prescaler width

	// ------------------------------------------------------------
	// reset_cause_and_enable field positions
	// ------------------------------------------------------------
	localparam int BIT_PIN = 0; // pin_reset_flag
	localparam int BIT_POR = 1; // power_on_flag_monitor_enable
	localparam int BIT_CLK = 2; // clock_loss_flag_enable
	localparam int BIT_WDT = 3; // watchdog_reset_flag
	localparam int BIT_SW = 4; // software_reset_force_flag
	localparam int BIT_CMP = 5; // comparator_reset_flag_enable
	localparam int BIT_ILL = 6; // illegal_access_reset_flag
	localparam logic [REG_W-1:0] FLAGS_POWER_ON = 8'h02; // after power-on
	localparam logic [REG_W-1:0] FLAGS_NONE = 8'h00; // no cause

	// ------------------------------------------------------------
	// user code space limits per memory size
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] LIMIT_8K = 16'h1dff;
	localparam logic [ADDR_W-1:0] LIMIT_4K = 16'h0fff;
	localparam logic [ADDR_W-1:0] LIMIT_2K = 16'h07ff;

	// sequencer states
	typedef enum logic [1:0] {
		RSC_RUN = 2'b00, // code running
		RSC_HOLD = 2'b01, // level source still active
		RSC_DELAY = 2'b10 // release delay before execution
	} rsc_state_e;

endpackage

// file: rsc_reset_source_controller.sv
// reset source collection, cause register and release sequencer
`timescale 1ns/1ps
module rsc_reset_source_controller #(
	parameter int CLOSS_CYCLES = rsc_pkg::CLOSS_TYP_CYC, // clock-loss count
	parameter logic [15:0] USER_CODE_LIMIT = rsc_pkg::LIMIT_8K // code top
) (
	input wire logic i_clock, // 40 mhz clock
	input wire logic i_rstn, // power-on reset, sync, active low
	input wire logic i_reg_wr, // register write strobe
	input wire logic [rsc_pkg::REG_W-1:0] i_reg_wdata, // write data
	output logic [rsc_pkg::REG_W-1:0] o_reg_rdata, // cause flags
	input wire logic i_system_clock, // monitored system clock level
	input wire logic i_supply_low, // supply below threshold
	input wire logic i_pin_reset_n, // reset pin level, active low
	input wire logic i_comparator_out, // comparator output
	input wire logic i_watchdog_expired, // watchdog timeout pulse
	input wire logic i_watchdog_disable, // software disables watchdog
	input wire logic i_program_store_write_enable, // store writes on
	input wire logic i_data_move_write, // data move write/erase
	input wire logic i_code_read, // code read instruction
	input wire logic i_branch_fetch, // fetch after branch
	input wire logic [rsc_pkg::ADDR_W-1:0] i_code_addr, // target address
	output logic o_system_reset, // system reset to core, active high
	output logic o_reset_pin_out, // reset pin drive level
	output logic o_reset_pin_oe, // reset pin drive enable
	output logic o_monitor_enable, // supply monitor enable
	output logic o_watchdog_enable, // watchdog function enable
	output logic o_watchdog_tick // watchdog clock, i_clock/12 pulse
);
	import rsc_pkg::*;

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	generate
		if (CLOSS_CYCLES < 2 || CLOSS_CYCLES > (2 ** CNT_W) - 1) begin : g_cc
			$error("clock-loss count out of counter range");
		end
		if (USER_CODE_LIMIT != LIMIT_8K && USER_CODE_LIMIT != LIMIT_4K &&
			USER_CODE_LIMIT != LIMIT_2K) begin : g_lim
			$error("unsupported user code limit");
		end
	endgenerate

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	rsc_state_e state_q; // sequencer state
	rsc_state_e state_d; // next sequencer state
	logic [REG_W-1:0] flags_q; // reset cause flags
	logic [REG_W-1:0] cause_d; // one-hot cause of new reset
	logic clk_en_q; // clock-loss detector enable
	logic cmp_en_q; // comparator reset enable
	logic mon_en_q; // supply monitor enable
	logic sclk_q; // previous system clock level
	logic [CNT_W-1:0] clk_cnt_q; // cycles since last rising edge
	logic [DLY_W-1:0] dly_q; // release delay count
	logic [PRE_W-1:0] pre_q; // watchdog prescaler
	logic run; // code running
	logic closs_evt; // clock-loss timeout
	logic ill_evt; // illegal code access
	logic sw_evt; // software force
	logic mon_evt; // monitor newly enabled
	logic level_hold; // a level source still asserted
	logic any_src; // some source requests reset

	assign run = (state_q == RSC_RUN);

	// ------------------------------------------------------------
	// clock-loss detector
	// ------------------------------------------------------------
	// counts cycles since the last rising edge of the system clock
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			sclk_q <= 1'b0;
			clk_cnt_q <= '0;
		end else begin
			sclk_q <= i_system_clock;
			if (!clk_en_q || (i_system_clock && !sclk_q)) begin
				clk_cnt_q <= '0;
			end else if (!closs_evt) begin
				clk_cnt_q <= clk_cnt_q + 1'b1;
			end
		end
	end

	assign closs_evt = clk_en_q &&
		(clk_cnt_q == CNT_W'(CLOSS_CYCLES - 1));

	// ------------------------------------------------------------
	// source decode
	// ------------------------------------------------------------
	// guarded store access check
	assign ill_evt = ((i_program_store_write_enable && i_data_move_write) ||
		i_code_read || i_branch_fetch) && (i_code_addr > USER_CODE_LIMIT);
	assign sw_evt = i_reg_wr && i_reg_wdata[BIT_SW];
	assign mon_evt = i_reg_wr && i_reg_wdata[BIT_POR] && !mon_en_q;
	assign level_hold = !i_pin_reset_n || (mon_en_q && i_supply_low) ||
		(flags_q[BIT_CMP] && !i_comparator_out);

	// priority encode of the cause, highest first
	always_comb begin
		cause_d = FLAGS_NONE;
		any_src = 1'b1;
		if (mon_en_q && i_supply_low) begin
			cause_d[BIT_POR] = 1'b1; // supply monitor
		end else if (!i_pin_reset_n) begin
			cause_d[BIT_PIN] = 1'b1;
		end else if (mon_evt) begin
			cause_d[BIT_POR] = 1'b1; // monitor enable counts as monitor
		end else if (closs_evt) begin
			cause_d[BIT_CLK] = 1'b1;
		end else if (cmp_en_q && !i_comparator_out) begin
			cause_d[BIT_CMP] = 1'b1;
		end else if (i_watchdog_expired) begin
			cause_d[BIT_WDT] = 1'b1;
		end else if (ill_evt) begin
			cause_d[BIT_ILL] = 1'b1;
		end else if (sw_evt) begin
			cause_d[BIT_SW] = 1'b1; // software force
		end else begin
			any_src = 1'b0; // nothing pending
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	// next state: hold while a level source stays, then delay
	always_comb begin
		state_d = state_q;
		case (state_q)
			RSC_RUN: begin
				if (any_src) begin
					state_d = RSC_HOLD;
				end
			end
			RSC_HOLD: begin
				if (!level_hold) begin
					state_d = RSC_DELAY;
				end
			end
			RSC_DELAY: begin
				if (level_hold) begin
					state_d = RSC_HOLD; // source came back
				end else if (dly_q == DLY_W'(RESET_DELAY_CYC - 1)) begin
					state_d = RSC_RUN;
				end
			end
			default: begin
				state_d = RSC_HOLD;
			end
		endcase
	end

	// state register; power-on passes hold so the delay is a full 5.0 us
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			state_q <= RSC_HOLD;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			dly_q <= '0;
		end else if (state_q != RSC_DELAY) begin
			dly_q <= '0;
		end else begin
			dly_q <= dly_q + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// cause flags and enables
	// ------------------------------------------------------------
	// flags change only as a reset starts
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			flags_q <= FLAGS_POWER_ON;
		end else if (run && any_src) begin
			// one-hot cause, bit 7 never set
			flags_q <= cause_d;
		end
	end

	// enables written by software; writes ignored while in reset
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			clk_en_q <= 1'b0;
			cmp_en_q <= 1'b0;
		end else if (run && any_src) begin
			clk_en_q <= 1'b0; // every reset disarms detectors
			cmp_en_q <= 1'b0;
		end else if (run && i_reg_wr) begin
			clk_en_q <= i_reg_wdata[BIT_CLK];
			cmp_en_q <= i_reg_wdata[BIT_CMP];
		end
	end

	// supply monitor enable survives all but power-on
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			mon_en_q <= 1'b0;
		end else if (run && i_reg_wr && !(any_src && !mon_evt)) begin
			mon_en_q <= i_reg_wdata[BIT_POR];
		end
	end

	// ------------------------------------------------------------
	// watchdog clock and enable
	// ------------------------------------------------------------
	// divide by twelve, enabled at reset
	always_ff @(posedge i_clock) begin
		if (!i_rstn || state_d != RSC_RUN) begin
			pre_q <= '0;
			o_watchdog_tick <= 1'b0;
			o_watchdog_enable <= 1'b1;
		end else begin
			o_watchdog_tick <= (pre_q == PRE_W'(WDT_PRESCALE - 1));
			if (pre_q == PRE_W'(WDT_PRESCALE - 1)) begin
				pre_q <= '0;
			end else begin
				pre_q <= pre_q + 1'b1;
			end
			if (i_watchdog_disable) begin
				o_watchdog_enable <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	assign o_reg_rdata = flags_q;
	assign o_monitor_enable = mon_en_q;

	// system reset and pin drive follow the next state
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			o_system_reset <= 1'b1;
			o_reset_pin_out <= 1'b0;
			o_reset_pin_oe <= 1'b1;
		end else begin
			o_system_reset <= (state_d != RSC_RUN);
			o_reset_pin_out <= 1'b0;
			// only power-on and monitor resets drive the pin
			if (state_d == RSC_RUN) begin
				o_reset_pin_oe <= 1'b0;
			end else if (run && any_src) begin
				o_reset_pin_oe <= cause_d[BIT_POR];
			end
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rstn);

	logic [DLY_W:0] rst_len_q; // helper: consecutive reset cycles
	always_ff @(posedge i_clock) begin
		if (!i_rstn || !o_system_reset) begin
			rst_len_q <= '0;
		end else if (rst_len_q != '1) begin
			rst_len_q <= rst_len_q + 1'b1;
		end
	end

	property p_closs_time;
		$rose(o_system_reset) && o_reg_rdata[BIT_CLK] |->
			$past(clk_cnt_q) == CNT_W'(CLOSS_CYCLES - 1);
	endproperty
	a_closs_time: assert property (p_closs_time) else $error("clock loss early");

	property p_pin_drive;
		o_reset_pin_oe |-> o_system_reset && o_reg_rdata[BIT_POR];
	endproperty
	a_pin_drive: assert property (p_pin_drive) else $error("pin driven");

	property p_cmp_cause;
		$rose(o_system_reset) && o_reg_rdata[BIT_CMP] |->
			$past(cmp_en_q && !i_comparator_out);
	endproperty
	a_cmp_cause: assert property (p_cmp_cause) else $error("bad cmp cause");

	property p_wdt_cause;
		$rose(o_system_reset) && o_reg_rdata[BIT_WDT] |->
			$past(i_watchdog_expired);
	endproperty
	a_wdt_cause: assert property (p_wdt_cause) else $error("bad wdt cause");

	property p_ill_cause;
		$rose(o_system_reset) && o_reg_rdata[BIT_ILL] |-> $past(ill_evt);
	endproperty
	a_ill_cause: assert property (p_ill_cause) else $error("bad ill cause");

	property p_sw_force;
		!o_system_reset && i_reg_wr && i_reg_wdata[BIT_SW] |=>
			o_system_reset ##1 o_system_reset;
	endproperty
	a_sw_force: assert property (p_sw_force) else $error("no sw reset");

	property p_release_delay;
		$fell(o_system_reset) |->
			$past(rst_len_q) >= (DLY_W + 1)'(RESET_DELAY_CYC);
	endproperty
	a_release_delay: assert property (p_release_delay) else $error("short delay");

	property p_one_cause;
		$rose(o_system_reset) |-> $onehot(o_reg_rdata) && !o_reg_rdata[7];
	endproperty
	a_one_cause: assert property (p_one_cause) else $error("not one-hot");

	property p_mon_enable;
		!o_system_reset && !o_monitor_enable && i_reg_wr &&
			i_reg_wdata[BIT_POR] |=> o_system_reset && o_monitor_enable;
	endproperty
	a_mon_enable: assert property (p_mon_enable) else $error("mon no reset");

	property p_mon_keep;
		$rose(o_system_reset) && !o_reg_rdata[BIT_POR] |->
			o_monitor_enable == $past(o_monitor_enable);
	endproperty
	a_mon_keep: assert property (p_mon_keep) else $error("mon lost");

	property p_wdt_on;
		o_system_reset |=> o_watchdog_enable;
	endproperty
	a_wdt_on: assert property (p_wdt_on) else $error("wdt off");

endmodule // rsc_reset_source_controller

// file: rsc_reset_source_controller_bench.sv
// self-checking bench of the reset source controller
`timescale 1ns/1ps
module rsc_reset_source_controller_bench;
	import rsc_pkg::*;
	localparam logic [15:0] LIM = LIMIT_4K; // 4k code variant
	logic i_clock = 0, i_rstn = 0, i_reg_wr = 0, i_supply_low = 0;
	logic i_pin_reset_n = 1, i_comparator_out = 1, i_watchdog_expired = 0;
	logic i_watchdog_disable = 0, i_program_store_write_enable = 0;
	logic i_data_move_write = 0, i_code_read = 0, i_branch_fetch = 0;
	logic stop_clk = 0; // freeze the system clock
	logic [7:0] i_reg_wdata = 8'h00;
	logic [15:0] i_code_addr = 16'h0000;
	logic i_system_clock, o_system_reset, o_reset_pin_out, o_reset_pin_oe;
	logic o_monitor_enable, o_watchdog_enable, o_watchdog_tick;
	logic [7:0] o_reg_rdata;
	int ticks, t0, n, kd, n_fail = 0, checks = 0, seed = 32'h48ca;
	logic [31:0] r;
	logic we;
	always #12.5 i_clock = ~i_clock;
	rsc_reset_source_controller #(.CLOSS_CYCLES(20), .USER_CODE_LIMIT(LIM))
	i_rsc_reset_source_controller (.i_clock, .i_rstn, .i_reg_wr,
		.i_reg_wdata, .o_reg_rdata, .i_system_clock, .i_supply_low,
		.i_pin_reset_n, .i_comparator_out, .i_watchdog_expired,
		.i_watchdog_disable, .i_program_store_write_enable,
		.i_data_move_write, .i_code_read, .i_branch_fetch, .i_code_addr,
		.o_system_reset, .o_reset_pin_out, .o_reset_pin_oe,
		.o_monitor_enable, .o_watchdog_enable, .o_watchdog_tick);
	rsc_core_model i_rsc_core_model (.i_clock(i_clock),
		.i_system_reset(o_system_reset), .i_stop(stop_clk),
		.i_watchdog_tick(o_watchdog_tick),
		.o_system_clock(i_system_clock), .o_ticks(ticks));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task give_verdict;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task cyc(input int k);
		repeat (k) @(negedge i_clock);
	endtask
	task done(input string nm);
		$display("test %s done", nm);
	endtask
	task no_rst(input int k);
		cyc(k);
		chk("no reset", 8'h00, {7'h0, o_system_reset});
	endtask
	task wr(input logic [7:0] d);
		i_reg_wdata = d;
		i_reg_wr = 1;
		cyc(1);
		i_reg_wr = 0;
	endtask
	// bounded wait for reset entry, then cause and pin checks
	task hit(input logic [7:0] f, input logic oe);
		n = 0;
		while (o_system_reset !== 1'b1 && n < 40) begin
			cyc(1);
			n++;
		end
		chk("reset entry", 8'h01, {7'h0, o_system_reset});
		chk("cause flags", f, o_reg_rdata);
		chk("pin drive", {7'h0, oe}, {7'h0, o_reset_pin_oe});
		chk("pin level", 8'h00, {7'h0, o_reset_pin_out});
		if (n == 40)
			give_verdict();
	endtask
	// bounded wait for release, length includes any hold
	task rel;
		n = 0;
		while (o_system_reset === 1'b1 && n < 3000) begin
			cyc(1);
			n++;
		end
		chk("release delay", 8'h01, {7'h0, n >= RESET_DELAY_CYC && n < 300});
		if (n == 3000)
			give_verdict();
		else
			cyc(2);
	endtask
	function automatic logic exp_ill(logic [15:0] a, int k, logic w);
		return a > LIM && (k != 0 || w);
	endfunction
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		cyc(3);
		chk("por flags", FLAGS_POWER_ON, o_reg_rdata);
		chk("por pin", 8'h01, {7'h0, o_reset_pin_oe});
		chk("por monitor", 8'h00, {7'h0, o_monitor_enable});
		i_rstn = 1;
		rel();
		done("power on");
		wr(8'h00);
		no_rst(5);
		wr(8'h80);
		no_rst(5);
		chk("bit7", 8'h00, {7'h0, o_reg_rdata[7]});
		done("write zero");
		i_watchdog_expired = 1;
		cyc(1);
		i_watchdog_expired = 0;
		hit(8'h08, 0);
		chk("wd on", 8'h01, {7'h0, o_watchdog_enable});
		rel();
		cyc(12);
		t0 = ticks;
		cyc(120);
		chk("wd ticks", 8'd10, 8'(ticks - t0));
		i_watchdog_disable = 1;
		cyc(2);
		i_watchdog_disable = 0;
		chk("wd off", 8'h00, {7'h0, o_watchdog_enable});
		wr(8'h10);
		hit(8'h10, 0);
		chk("wd back", 8'h01, {7'h0, o_watchdog_enable});
		rel();
		done("watchdog and software");
		// illegal accesses: corners then random targets
		for (int k = 0; k < 12; k++) begin
			r = $random(seed);
			kd = k % 3;
			we = r[16] | (k == 3);
			i_program_store_write_enable = we;
			i_code_addr = (k < 4) ? LIM + {15'h0, k[0]} : r[15:0];
			i_data_move_write = kd == 0;
			i_code_read = kd == 1;
			i_branch_fetch = kd == 2;
			cyc(1);
			i_data_move_write = 0;
			i_code_read = 0;
			i_branch_fetch = 0;
			if (exp_ill(i_code_addr, kd, we)) begin
				hit(8'h40, 0);
				rel();
			end else
				no_rst(2);
		end
		i_program_store_write_enable = 0;
		done("illegal access");
		// comparator held high and settled before arming
		i_comparator_out = 1;
		wr(8'h20);
		cyc(1);
		wr(8'h00);
		i_comparator_out = 0;
		no_rst(5);
		i_comparator_out = 1;
		wr(8'h20);
		no_rst(5);
		i_comparator_out = 0;
		hit(8'h20, 0);
		cyc(30);
		chk("cmp hold", 8'h01, {7'h0, o_system_reset});
		i_comparator_out = 1;
		rel();
		done("comparator");
		wr(8'h04);
		no_rst(5);
		stop_clk = 1;
		no_rst(16);
		hit(8'h04, 0);
		stop_clk = 0;
		rel();
		wr(8'h04);
		cyc(1);
		wr(8'h00);
		stop_clk = 1;
		no_rst(60);
		stop_clk = 0;
		done("clock loss");
		wr(8'h02);
		hit(8'h02, 1);
		rel();
		chk("mon on", 8'h01, {7'h0, o_monitor_enable});
		wr(8'h02);
		no_rst(5);
		wr(8'h12);
		hit(8'h10, 0);
		rel();
		chk("mon kept", 8'h01, {7'h0, o_monitor_enable});
		i_supply_low = 1;
		hit(8'h02, 1);
		cyc(10);
		i_supply_low = 0;
		rel();
		i_pin_reset_n = 0;
		hit(8'h01, 0);
		cyc(10);
		i_pin_reset_n = 1;
		rel();
		chk("mon kept", 8'h01, {7'h0, o_monitor_enable});
		i_rstn = 0;
		cyc(2);
		chk("mon off", 8'h00, {7'h0, o_monitor_enable});
		i_rstn = 1;
		rel();
		done("monitor and pin");
		give_verdict();
	end
endmodule // rsc_reset_source_controller_bench
